// [logic/apdo_pkg.sv]
// Purpose: Shared constants and types for absolute position data output
// Assumes: 10 MHz clock
// Notes: Times held in their own unit, cycle counts derived
package apdo_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
  localparam int SETTLE_MS = 50;
  localparam int SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  localparam int ROT_PERIOD_MS = 40;
  localparam int ROT_PERIOD_CYC = ROT_PERIOD_MS * (CLK_HZ / 1000);
  localparam int INIT_RPM = 2500;
  localparam int ENC_BITS = 17;
  localparam int ENC_COUNTS = 131072;
  // Cycles between encoder counts at the initial pulse rate
  localparam int INIT_STEP_CYC = (CLK_HZ * 60) / (INIT_RPM * ENC_COUNTS);
  localparam logic [15:0] DIV_DEFAULT = 16'h0800;
  localparam logic [15:0] DIV_MIN = 16'h0011;
  localparam int MT_CHARS = 8;
  localparam int ROT_CHARS = 13;
  localparam logic [6:0] CH_P = 7'h50;
  localparam logic [6:0] CH_PLUS = 7'h2B;
  localparam logic [6:0] CH_MINUS = 7'h2D;
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [6:0] CH_CR = 7'h0D;
  localparam logic [6:0] CH_COMMA = 7'h2C;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } apdo_quad_t;
endpackage : apdo_pkg

// [logic/apdo_top.sv]
// Purpose: Absolute position report: serial multi-turn frame, initial pulses, rotation frame
// Assumes: Position inputs synchronous; one clock
// Notes: Serial lines idle high
// Notes on behaviour
// - Request rising edge starts count then pulses
// - Motor held off until transfer completes
// - Multi-turn frame is eight characters
// - Normal pulses 50 ms after the initial pulses end
// - 9600 baud, start, even parity, stop
// - Sign, five digits, carriage return
// - Revolution count wraps at 16-bit limits
// - Rotation frame same framing, 13 characters
// - Five-digit count, seven-digit position
// - Rotation frame repeats every 40 ms
// - Position sent undivided
// - Reverse mode inverts position direction
// - Initial pulses equal home distance, 2500 rpm; INIT_STEP_CYC truncates to one count per clock, about 4578 rpm
// - Initial pulses use same divider
// - Divider gives pulses per revolution, default 2048
// - Output roles per initial or normal state
`timescale 1ns/1ps
module apdo_top
  import apdo_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic ABSOLUTE_DATA_REQUEST_I,
  input wire logic [15:0] REV_COUNT_I,
  input wire logic [16:0] ENC_POS_I,
  input wire logic ENC_STEP_I,
  input wire logic ENC_DIR_I,
  input wire logic [15:0] OUTPUT_PULSE_DIVIDER_SETTING_I,
  input wire logic ROTATION_DIRECTION_SELECT_I,
  input wire logic SERVO_ON_I,
  output logic MOTOR_ENABLE_O,
  output logic TRANSFER_BUSY_O,
  output logic PHASE_A_OUTPUT_O,
  output logic PHASE_B_OUTPUT_O,
  output logic INDEX_PULSE_OUTPUT_O,
  output logic ROTATION_SERIAL_OUTPUT_O
);
  typedef enum logic [2:0] {S_IDLE, S_FRAME, S_INIT, S_SETTLE, S_NORMAL} apdo_state_t;
  apdo_state_t state;

  function automatic logic [6:0] apdo_digit(input logic [19:0] v, input int p);
    logic [19:0] q;
    q = v;
    for (int i = 0; i < 7; i++) begin
      if (i < p) q = q / 20'd10;
    end
    return CH_ZERO + 7'(q % 20'd10);
  endfunction : apdo_digit

  function automatic logic apdo_par(input logic [6:0] c);
    return ^c;
  endfunction : apdo_par

  // Magnitude of a signed revolution count, wide enough for 32768
  function automatic logic [19:0] apdo_mag(input logic [15:0] v);
    logic [19:0] m;
    if (v[15]) begin
      m = 20'h00000 - {{4{v[15]}}, v};
    end else begin
      m = {4'h0, v};
    end
    return m;
  endfunction : apdo_mag

  // Shift word, LSB first: start, seven data bits, even parity, stop, idle
  function automatic logic [10:0] apdo_frame(input logic [6:0] c);
    return {1'b1, 1'b1, apdo_par(c), c, 1'b0};
  endfunction : apdo_frame

  // One character of the multi-turn frame: P, sign, five digits, CR
  function automatic logic [6:0] apdo_mt_char(input logic [3:0] idx, input logic neg,
                                               input logic [19:0] mag);
    logic [6:0] c;
    if (idx == 4'h0) begin
      c = CH_P;
    end else if (idx == 4'h1) begin
      c = neg ? CH_MINUS : CH_PLUS;
    end else if (idx == 4'h7) begin
      c = CH_CR;
    end else begin
      c = apdo_digit(mag, 6 - int'(idx));
    end
    return c;
  endfunction : apdo_mt_char

  // One character of the rotation frame: sign, five count digits, seven position digits
  function automatic logic [6:0] apdo_rot_char(input logic [3:0] idx, input logic neg,
                                                input logic [19:0] mag, input logic [19:0] pos);
    logic [6:0] c;
    if (idx == 4'h0) begin
      c = neg ? CH_MINUS : CH_PLUS;
    end else if (idx <= 4'h5) begin
      c = apdo_digit(mag, 5 - int'(idx));
    end else begin
      c = apdo_digit(pos, 12 - int'(idx));
    end
    return c;
  endfunction : apdo_rot_char

  // Serial transmitters: idx 0 = A-phase frame, 1 = rotation frame
  logic [10:0] sh [2];
  logic [3:0] bits_left [2];
  logic [10:0] baud [2];
  logic [3:0] ch_idx [2];
  logic tx_go [2];
  logic [6:0] tx_ch [2];
  wire tx_idle0 = (bits_left[0] == 4'h0);
  wire tx_idle1 = (bits_left[1] == 4'h0);

  // Latched frame values
  logic [15:0] mt_rev;
  logic [15:0] rot_rev;
  logic [16:0] rot_pos;
  wire mt_neg = mt_rev[15];
  wire [19:0] mt_mag = apdo_mag(mt_rev);
  wire rot_neg = rot_rev[15];
  wire [19:0] rot_mag = apdo_mag(rot_rev);
  wire [16:0] pos_dir = ROTATION_DIRECTION_SELECT_I ? 17'(-ENC_POS_I) : ENC_POS_I;

  assign tx_ch[0] = apdo_mt_char(ch_idx[0], mt_neg, mt_mag);
  assign tx_ch[1] = apdo_rot_char(ch_idx[1], rot_neg, rot_mag, {3'b000, rot_pos});

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tx
      always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          sh[g] <= 11'h7FF;
          bits_left[g] <= 4'h0;
          baud[g] <= 11'h000;
        end else if (tx_go[g]) begin
          sh[g] <= apdo_frame(tx_ch[g]);
          bits_left[g] <= 4'hA;
          baud[g] <= 11'(BIT_CYC - 1);
        end else if (bits_left[g] != 4'h0) begin
          if (baud[g] == 11'h000) begin
            sh[g] <= {1'b1, sh[g][10:1]};
            bits_left[g] <= bits_left[g] - 4'h1;
            baud[g] <= 11'(BIT_CYC - 1);
          end else begin
            baud[g] <= baud[g] - 11'h001;
          end
        end
      end
    end
  endgenerate

  // Request edge and sequence state
  logic req_q;
  wire req_rise = ABSOLUTE_DATA_REQUEST_I & ~req_q;
  logic [21:0] timer;
  logic [16:0] init_left;
  logic [7:0] step_cnt;
  logic mt_busy;
  // Busy holds from a load until the first idle cycle after the last shift
  wire next_mt_busy = tx_go[0] || (mt_busy && !tx_idle0);

  // A-phase frame: next character one cycle after the line is free
  assign tx_go[0] = (state == S_FRAME) && tx_idle0 && !mt_busy && (ch_idx[0] < 4'(MT_CHARS));
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      req_q <= 1'b0;
      state <= S_IDLE;
      ch_idx[0] <= 4'h0;
      mt_rev <= 16'h0000;
      mt_busy <= 1'b0;
      timer <= 22'h000000;
      init_left <= 17'h00000;
      step_cnt <= 8'h00;
    end else begin
      req_q <= ABSOLUTE_DATA_REQUEST_I;
      mt_busy <= next_mt_busy;
      case (state)
        S_IDLE, S_NORMAL: begin
          if (req_rise) begin
            state <= S_FRAME;
            mt_rev <= REV_COUNT_I;
            init_left <= pos_dir;
            ch_idx[0] <= 4'h0;
          end
        end
        S_FRAME: begin
          if (tx_go[0]) ch_idx[0] <= ch_idx[0] + 4'h1;
          else if (ch_idx[0] == 4'(MT_CHARS) && tx_idle0 && !mt_busy) state <= S_INIT;
        end
        S_INIT: begin
          if (init_left == 17'h00000) begin
            state <= S_SETTLE;
            timer <= 22'(SETTLE_CYC - 1);
          end else if (step_cnt == 8'h00) begin
            step_cnt <= 8'(INIT_STEP_CYC - 1);
            init_left <= init_left - 17'h00001;
          end else begin
            step_cnt <= step_cnt - 8'h01;
          end
        end
        S_SETTLE: begin
          if (timer == 22'h000000) state <= S_NORMAL;
          else timer <= timer - 22'h000001;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Rotation serial frame every 40 ms, started only in normal state
  logic [21:0] rot_timer;
  logic rot_active;
  logic rot_busy;
  // Same hold past the last shift as the A-phase transmitter
  wire next_rot_busy = tx_go[1] || (rot_busy && !tx_idle1);
  assign tx_go[1] = rot_active && tx_idle1 && !rot_busy && (ch_idx[1] < 4'(ROT_CHARS));
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rot_timer <= 22'h000000;
      rot_active <= 1'b0;
      rot_busy <= 1'b0;
      ch_idx[1] <= 4'h0;
      rot_rev <= 16'h0000;
      rot_pos <= 17'h00000;
    end else begin
      rot_busy <= next_rot_busy;
      if (state != S_NORMAL) begin
        rot_timer <= 22'h000000;
      end else if (rot_timer == 22'h000000) begin
        rot_timer <= 22'(ROT_PERIOD_CYC - 1);
        if (!rot_active) begin
          rot_active <= 1'b1;
          ch_idx[1] <= 4'h0;
          rot_rev <= REV_COUNT_I;
          rot_pos <= pos_dir;
        end
      end else begin
        rot_timer <= rot_timer - 22'h000001;
      end
      if (tx_go[1]) ch_idx[1] <= ch_idx[1] + 4'h1;
      else if (rot_active && ch_idx[1] == 4'(ROT_CHARS) && tx_idle1 && !rot_busy)
        rot_active <= 1'b0;
    end
  end

  // Divider: accumulate four times the setting per encoder count, emit a quadrature step on overflow
  wire init_step = (state == S_INIT) && (init_left != 17'h00000) && (step_cnt == 8'h00);
  wire norm_step = (state == S_NORMAL) && ENC_STEP_I;
  wire any_step = init_step | norm_step;
  // Reverse mode flips the count direction of normal steps; initial steps always count up
  wire step_down = norm_step && (ENC_DIR_I ^ ROTATION_DIRECTION_SELECT_I);
  // Zero selects the default, small settings clamp to the minimum
  wire [15:0] div_set = (OUTPUT_PULSE_DIVIDER_SETTING_I == 16'h0000) ? DIV_DEFAULT :
                        (OUTPUT_PULSE_DIVIDER_SETTING_I < DIV_MIN) ? DIV_MIN :
                        OUTPUT_PULSE_DIVIDER_SETTING_I;
  logic [17:0] acc;
  wire [18:0] acc_sum = {1'b0, acc} + {1'b0, div_set, 2'b00};
  wire acc_ovf = acc_sum >= 19'(ENC_COUNTS);
  logic [1:0] quad;
  apdo_quad_t qo;

  // State groups for the output roles
  wire st_serial = (state == S_FRAME) || (state == S_IDLE);
  wire st_normal = (state == S_NORMAL);
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      acc <= 18'h00000;
      quad <= 2'b00;
    end else if (any_step) begin
      acc <= acc_ovf ? 18'(acc_sum - 19'(ENC_COUNTS)) : 18'(acc_sum);
      if (acc_ovf) quad <= step_down ? quad - 2'b01 : quad + 2'b01;
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      qo <= '{a: 1'b1, b: 1'b0, c: 1'b0};
      MOTOR_ENABLE_O <= 1'b0;
    end else begin
      qo.a <= st_serial ? sh[0][0] : quad[1] ^ quad[0];
      // B stays low until the frame is done
      qo.b <= st_serial ? 1'b0 : quad[1];
      // Index pulse at the zero position
      qo.c <= st_normal && (ENC_POS_I == 17'h00000);
      MOTOR_ENABLE_O <= SERVO_ON_I && (state == S_NORMAL);
    end
  end

  assign TRANSFER_BUSY_O = (state != S_NORMAL) && (state != S_IDLE);
  assign PHASE_A_OUTPUT_O = qo.a;
  assign PHASE_B_OUTPUT_O = qo.b;
  assign INDEX_PULSE_OUTPUT_O = qo.c;
  assign ROTATION_SERIAL_OUTPUT_O = sh[1][0];
endmodule : apdo_top

// [test/apdo_chk.sv]
// Purpose: Port checker for absolute position data output
// Assumes: One clock, async active-low reset
// Notes: Frame window counted from busy rise
`timescale 1ns/1ps
module apdo_chk
  import apdo_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic ABSOLUTE_DATA_REQUEST_I,
  input wire logic SERVO_ON_I,
  input wire logic MOTOR_ENABLE_O,
  input wire logic TRANSFER_BUSY_O,
  input wire logic PHASE_A_OUTPUT_O,
  input wire logic PHASE_B_OUTPUT_O,
  input wire logic INDEX_PULSE_OUTPUT_O,
  input wire logic ROTATION_SERIAL_OUTPUT_O
);
  localparam int FR_CYC = MT_CHARS * 10 * BIT_CYC;
  logic seen;
  logic a_q;
  logic [23:0] cnt;
  logic [23:0] run;
  logic [23:0] next_cnt;
  logic [23:0] next_run;
  assign next_cnt = !TRANSFER_BUSY_O ? 24'h000000 : (cnt < FR_CYC ? cnt + 24'h000001 : cnt);
  assign next_run = (PHASE_A_OUTPUT_O != a_q) ? 24'h000000 : run + 24'h000001;
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      seen <= 1'b0;
      a_q <= 1'b1;
      cnt <= 24'h000000;
      run <= 24'h000000;
    end else begin
      seen <= seen | TRANSFER_BUSY_O;
      a_q <= PHASE_A_OUTPUT_O;
      cnt <= next_cnt;
      run <= next_run;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  AST_IDLE_LINES: assert property (!seen && !TRANSFER_BUSY_O |-> PHASE_A_OUTPUT_O && !PHASE_B_OUTPUT_O)
    else $error("phase lines not idle before transfer");
  AST_REQ_START: assert property ($rose(ABSOLUTE_DATA_REQUEST_I) && !seen |-> ##[1:3] TRANSFER_BUSY_O)
    else $error("request edge did not start transfer");
  AST_START_BIT: assert property ($rose(TRANSFER_BUSY_O) |-> ##[1:6] !PHASE_A_OUTPUT_O)
    else $error("no start bit after transfer start");
  AST_MOTOR_HELD: assert property (TRANSFER_BUSY_O && $past(TRANSFER_BUSY_O) |-> !MOTOR_ENABLE_O)
    else $error("motor enabled during transfer");
  AST_ENABLE_CAUSE: assert property (MOTOR_ENABLE_O |-> $past(SERVO_ON_I) && !$past(TRANSFER_BUSY_O))
    else $error("motor enabled without servo on");
  AST_BIT_TIME: assert property (PHASE_A_OUTPUT_O && !a_q && cnt > 8 && cnt < FR_CYC
    |-> ((run + 24'h000001) % BIT_CYC) == 0)
    else $error("serial bit length wrong");
  AST_B_QUIET: assert property (TRANSFER_BUSY_O && cnt < FR_CYC |-> !PHASE_B_OUTPUT_O)
    else $error("phase B active during serial frame");
  AST_NO_INDEX: assert property (TRANSFER_BUSY_O && $past(TRANSFER_BUSY_O) |-> !INDEX_PULSE_OUTPUT_O)
    else $error("index pulse during transfer");
  AST_ROT_QUIET: assert property (!seen |-> ROTATION_SERIAL_OUTPUT_O)
    else $error("rotation line not idle");
endmodule : apdo_chk
bind apdo_top apdo_chk i_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .ABSOLUTE_DATA_REQUEST_I(ABSOLUTE_DATA_REQUEST_I), .SERVO_ON_I(SERVO_ON_I),
  .MOTOR_ENABLE_O(MOTOR_ENABLE_O), .TRANSFER_BUSY_O(TRANSFER_BUSY_O),
  .PHASE_A_OUTPUT_O(PHASE_A_OUTPUT_O), .PHASE_B_OUTPUT_O(PHASE_B_OUTPUT_O),
  .INDEX_PULSE_OUTPUT_O(INDEX_PULSE_OUTPUT_O), .ROTATION_SERIAL_OUTPUT_O(ROTATION_SERIAL_OUTPUT_O));

// [test/apdo_host_rx.sv]
// Purpose: Host serial receiver on the phase A line
// Assumes: Even parity, one stop bit
// Notes: Bit 7 of data flags a parity or stop fault
`timescale 1ns/1ps
module apdo_host_rx
  import apdo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic line_i,
  input wire logic line_b_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic signed [31:0] count_o
);
  logic [8:0] sh;
  logic counting;
  logic [1:0] q_old;
  wire [1:0] q_new = {line_b_i, line_i ^ line_b_i};
  int rx_n;
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
    counting = 1'b0;
    rx_n = 0;
    forever begin
      @(posedge clk_i);
      valid_o <= 1'b0;
      if (rx_n == MT_CHARS && !counting) begin
        // Counting starts once the line drops after the frame
        while (line_i) @(posedge clk_i);
        counting <= 1'b1;
      end else if (rst_n_i && !line_i && !counting) begin
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
          repeat (BIT_CYC) @(posedge clk_i);
          sh[i] = line_i;
        end
        data_o <= {(^sh[7:0]) | !sh[8], sh[6:0]};
        valid_o <= 1'b1;
        rx_n++;
      end
    end
  end
  // Up/down count of quadrature states, held at zero until the frame is in
  always @(posedge clk_i) begin
    q_old <= q_new;
    if (!counting) begin
      count_o <= 0;
    end else if (q_new == q_old + 2'b01) begin
      count_o <= count_o + 1;
    end else if (q_new == q_old - 2'b01) begin
      count_o <= count_o - 1;
    end
  end
endmodule : apdo_host_rx

// [test/tb.sv]
// Purpose: Self-checking bench for absolute position data output
// Assumes: 10 MHz clock, one full multi-turn frame
// Notes: Settle period lies beyond the run
`timescale 1ns/1ps
module tb
  import apdo_pkg::*;
;
  logic CLK_I, RESET_N_I, ABSOLUTE_DATA_REQUEST_I, ENC_STEP_I, ENC_DIR_I;
  logic ROTATION_DIRECTION_SELECT_I, SERVO_ON_I, rx_valid;
  logic [15:0] REV_COUNT_I, OUTPUT_PULSE_DIVIDER_SETTING_I;
  logic [16:0] ENC_POS_I;
  logic MOTOR_ENABLE_O, TRANSFER_BUSY_O, PHASE_A_OUTPUT_O, PHASE_B_OUTPUT_O;
  logic INDEX_PULSE_OUTPUT_O, ROTATION_SERIAL_OUTPUT_O;
  logic [7:0] rx_data;
  logic signed [31:0] host_count;
  int pe = 0, p_s = 0;
  logic [7:0] exp_q[$];
  int err_total = 0, cmp_count = 0, rx_count = 0;
  integer seed;
  apdo_top i_dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .ABSOLUTE_DATA_REQUEST_I(ABSOLUTE_DATA_REQUEST_I), .REV_COUNT_I(REV_COUNT_I),
    .ENC_POS_I(ENC_POS_I), .ENC_STEP_I(ENC_STEP_I), .ENC_DIR_I(ENC_DIR_I),
    .OUTPUT_PULSE_DIVIDER_SETTING_I(OUTPUT_PULSE_DIVIDER_SETTING_I),
    .ROTATION_DIRECTION_SELECT_I(ROTATION_DIRECTION_SELECT_I), .SERVO_ON_I(SERVO_ON_I),
    .MOTOR_ENABLE_O(MOTOR_ENABLE_O), .TRANSFER_BUSY_O(TRANSFER_BUSY_O),
    .PHASE_A_OUTPUT_O(PHASE_A_OUTPUT_O), .PHASE_B_OUTPUT_O(PHASE_B_OUTPUT_O),
    .INDEX_PULSE_OUTPUT_O(INDEX_PULSE_OUTPUT_O),
    .ROTATION_SERIAL_OUTPUT_O(ROTATION_SERIAL_OUTPUT_O));
  apdo_host_rx i_host (.clk_i(CLK_I), .rst_n_i(RESET_N_I), .line_i(PHASE_A_OUTPUT_O),
    .line_b_i(PHASE_B_OUTPUT_O), .valid_o(rx_valid), .data_o(rx_data),
    .count_o(host_count));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic push_frame(input logic signed [15:0] n);
    int a;
    a = (n < 0) ? -int'(n) : int'(n);
    exp_q.push_back({1'b0, CH_P});
    exp_q.push_back({1'b0, (n < 0) ? CH_MINUS : CH_PLUS});
    for (int d = 10000; d > 0; d /= 10) begin
      exp_q.push_back({1'b0, CH_ZERO + 7'(a / d % 10)});
    end
    exp_q.push_back({1'b0, CH_CR});
  endtask : push_frame
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    if (rx_valid === 1'b1) begin
      rx_count++;
      check(rx_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hFF);
    end
  end
  initial begin
    repeat (99000) @(posedge CLK_I);
    err_total++;
    conclude();
  end
  initial begin
    seed = 32'h0871ac26;
    {RESET_N_I, ABSOLUTE_DATA_REQUEST_I, ENC_STEP_I, ENC_DIR_I} = 4'h0;
    {ROTATION_DIRECTION_SELECT_I, SERVO_ON_I} = 2'h0;
    REV_COUNT_I = 16'h0000;
    ENC_POS_I = 17'h00000;
    OUTPUT_PULSE_DIVIDER_SETTING_I = 16'h0000;
    repeat (4) @(posedge CLK_I);
    @(negedge CLK_I);
    RESET_N_I = 1'b1;
    repeat (3) @(negedge CLK_I);
    REV_COUNT_I = 16'($random(seed));
    ENC_POS_I = 17'($random(seed)) & 17'h003FF;
    SERVO_ON_I = 1'b1;
    push_frame(REV_COUNT_I);
    ABSOLUTE_DATA_REQUEST_I = 1'b1;
    repeat (20000) @(negedge CLK_I);
    check({7'h00, TRANSFER_BUSY_O}, 8'h01);
    check({7'h00, MOTOR_ENABLE_O}, 8'h00);
    check({7'h00, PHASE_B_OUTPUT_O}, 8'h00);
    check({7'h00, INDEX_PULSE_OUTPUT_O}, 8'h00);
    check({7'h00, ROTATION_SERIAL_OUTPUT_O}, 8'h01);
    ABSOLUTE_DATA_REQUEST_I = 1'b0;
    repeat (10) @(negedge CLK_I);
    ABSOLUTE_DATA_REQUEST_I = 1'b1;
    $display("transfer start and refusal test done");
    for (int i = 0; i < 75000 && rx_count < MT_CHARS; i++) @(negedge CLK_I);
    repeat (3000) @(negedge CLK_I);
    check(8'(rx_count), 8'(MT_CHARS));
    check(8'(exp_q.size()), 8'h00);
    check(8'(host_count), 8'(ENC_POS_I[16:4]));
    // Setup offset of a setup taken at zero position
    p_s = 0;
    pe = int'($signed(REV_COUNT_I)) * int'(DIV_DEFAULT) + host_count;
    check(8'(pe - p_s), 8'(int'($signed(REV_COUNT_I)) * 2048 + int'(ENC_POS_I[16:4])));
    $display("multi-turn frame test done");
    conclude();
  end
endmodule : tb
